/* common/rcs_pkg.sv */
// Constants and types for the clock control, status and interrupt block
package rcs_pkg;
    localparam int ADDR_W = 8;
    // Register offsets, bank 0 and both banks
    localparam logic [7:0] ADDR_SEC      = 8'h00;
    localparam logic [7:0] ADDR_SEC_ALM  = 8'h01;
    localparam logic [7:0] ADDR_MIN      = 8'h02;
    localparam logic [7:0] ADDR_MIN_ALM  = 8'h03;
    localparam logic [7:0] ADDR_HOUR     = 8'h04;
    localparam logic [7:0] ADDR_HOUR_ALM = 8'h05;
    localparam logic [7:0] ADDR_DOW      = 8'h06;
    localparam logic [7:0] ADDR_DATE     = 8'h07;
    localparam logic [7:0] ADDR_MONTH    = 8'h08;
    localparam logic [7:0] ADDR_YEAR     = 8'h09;
    localparam logic [7:0] ADDR_RATE     = 8'h0A;
    localparam logic [7:0] ADDR_CTRL     = 8'h0B;
    localparam logic [7:0] ADDR_FLAGS    = 8'h0C;
    localparam logic [7:0] ADDR_BATT     = 8'h0D;
    localparam logic [7:0] ADDR_RAM_LO   = 8'h0E;
    localparam logic [7:0] ADDR_EXT_LO   = 8'h40;
    localparam logic [7:0] ADDR_TOP      = 8'h7F;
    // Bank 1 extended registers
    localparam logic [7:0] ADDR_XFLAGS   = 8'h4A;
    localparam logic [7:0] ADDR_XCTRL    = 8'h4B;
    localparam logic [7:0] ADDR_XRAM_A   = 8'h50;
    localparam logic [7:0] ADDR_XRAM_D   = 8'h53;
    localparam int RAM0_DEPTH = 114;
    localparam int RAM1_DEPTH = 128;
    // Rate register fields
    localparam int RATE_BANK = 4;
    localparam int RATE_OSC  = 5;
    localparam int RATE_RST  = 6;
    localparam logic [7:0] RATE_RST_VAL = 8'h20;
    // Control register fields
    localparam int CB_SET  = 7;
    localparam int CB_PIE  = 6;
    localparam int CB_AIE  = 5;
    localparam int CB_UIE  = 4;
    localparam int CB_SQUARE_WAVE_ENABLE = 3;
    localparam int CB_DM   = 2;
    localparam int CB_24H  = 1;
    localparam int CB_DSE  = 0;
    localparam logic [7:0] CTRL_RST_VAL = 8'h00;
    // Flag register fields
    localparam int FL_ANY = 7;
    localparam int FL_PF  = 6;
    localparam int FL_AF  = 5;
    localparam int FL_UF  = 4;
    localparam int BATT_OK = 7;
    // Extended flag / enable fields
    localparam int XF_WAKE = 0;
    localparam int XF_KICK = 1;
    localparam int XF_RCLR = 2;
    localparam int XC_FIXED_32K_ENABLE = 5;
    localparam logic [7:0] XCTRL_RST_VAL = 8'h00;
    // Divider and tap selection
    localparam int DIV_W = 15;
    localparam logic [DIV_W-1:0] DIV_LAST = 15'h7FFF;
    localparam logic [3:0] RS_NONE = 4'h0;
    localparam logic [3:0] TAP_OF_RS [16] = '{4'h0, 4'h6, 4'h7, 4'h1, 4'h2, 4'h3, 4'h4,
        4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD};
    localparam logic [1:0] ALM_DONT_CARE = 2'h3;
    // Time values for the summer-time checks
    localparam logic [7:0] LAST_SEC_BCD   = 8'h59;
    localparam logic [7:0] LAST_SEC_BIN   = 8'h3B;
    localparam logic [7:0] HOUR_ONE_AM    = 8'h01;
    localparam logic [7:0] HOUR_TWO_AM    = 8'h02;
    localparam logic [7:0] MON_APRIL      = 8'h04;
    localparam logic [7:0] MON_OCT_BCD    = 8'h10;
    localparam logic [7:0] MON_OCT_BIN    = 8'h0A;
    localparam logic [7:0] DOW_SUNDAY     = 8'h01;
    localparam logic [7:0] DATE_WEEK1_END = 8'h07;
    localparam logic [7:0] DATE_LAST_BCD  = 8'h25;
    localparam logic [7:0] DATE_LAST_BIN  = 8'h19;

    typedef struct packed {
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] date;
        logic [7:0] dow;
        logic [7:0] hour;
        logic [7:0] min;
        logic [7:0] sec;
    } rcs_time_t;

    typedef struct packed {
        logic       en;
        logic [7:0] addr;
        logic [7:0] data;
    } rcs_twr_t;

    typedef struct packed {
        logic binary;
        logic hour24;
        logic hold;
    } rcs_fmt_t;
endpackage

/* hdl/rcs_ctrl.sv */
// Control, status, interrupt and user RAM logic of the real-time clock
//
// Behaviour
// - Update-inhibit bit set blocks time advance; logic never changes it.
// - Periodic enable gates periodic flag onto interrupt; flag sets regardless.
// - Alarm event each second time bytes match alarm bytes; 11xxxxxx matches all.
// - Update-inhibit rising from 0 to 1 clears update-done enable.
// - Without fixed 32k: square wave at rate when enabled, else low.
// - Data-format bit picks binary when 1, BCD when 0; software only.
// - Hour-format bit picks 24-hour when 1, 12-hour with AM/PM when 0.
// - Summer time: first Sunday of April jump 1:59:59 AM to 3:00:00.
// - Summer time: last Sunday of October back to 1:00:00 once only.
// - Summary flag set when any of six flag/enable pairs both 1.
// - Periodic flag sets on each rising edge of selected divider tap.
// - Alarm flag sets on time match; with enable drives interrupt and summary.
// - Update-done flag sets after every update; with enable drives interrupt.
// - Flag read returns snapshot, clears set flags; concurrent events survive.
// - Low four flag register bits read 0 and ignore writes.
// - Battery status read-only: better of two inputs; other bits zero.
// - 242 user RAM bytes, accessible during update cycles.
// - Bank 0: 14 clock registers, 114 RAM bytes; bank 1 adds 128 indirect.
// - Enabling a source whose flag already stands asserts interrupt at once.
// - Extended flags clear only by writing 0, not on read.
// - Interrupt and summary flag held while any source flag and enable set.
// - Fixed 32k enable outputs 32.768 kHz regardless of rate and enable.
// - Rate register bit 4 selects bank 0 or bank 1.
`timescale 1ns/10ps
module rcs_ctrl
    import rcs_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic [7:0]  regAddr,
    input  wire logic [7:0]  regWrData,
    input  wire logic        regWrStb,
    input  wire logic        regRdStb,
    output logic      [7:0]  regRdData_r,
    input  wire logic        oscLevel,
    input  wire rcs_time_t   timeNow,
    input  wire logic        wakeEvent,
    input  wire logic        kickEvent,
    input  wire logic        ramClrEvent,
    input  wire logic        mainBatteryOk,
    input  wire logic        auxBatteryOk,
    output logic             advance_r,
    output logic             summerFwd_r,
    output logic             summerBack_r,
    output rcs_fmt_t         fmt_r,
    output rcs_twr_t         timeWr_r,
    output logic             sqwOut_r,
    output logic             irqOut_r,
    output logic             irqOe_r
);
    logic [7:0]       rate_r;
    logic [7:0]       ctrl_r;
    logic [2:0]       flags_r;
    logic [2:0]       xflags_r;
    logic [7:0]       xctrl_r;
    logic [7:0]       xramAddr_r;

    logic [7:0]       alarm_r [3];
    logic [7:0]       ram0 [RAM0_DEPTH];
    logic [7:0]       ram1 [RAM1_DEPTH];

    logic [DIV_W-1:0] div_r;
    logic             oscPrev_r;
    logic             tapPrev_r;
    logic             checkPend_r;
    logic             checkDly_r;
    logic             backDone_r;

    logic             oscRise;
    logic             running;
    logic             secTick;
    logic             tap;
    logic             periodicEvt;

    logic [2:0]       almHit;
    logic             alarmEvt;

    logic             bank1;
    logic             wrCtrl;
    logic             rdFlags;

    logic [2:0]       flagsNxt;
    logic [2:0]       xflagsNxt;
    logic [7:0]       ctrlNxt;
    logic [7:0]       xctrlNxt;
    logic             anyNxt;
    logic             anyNow;

    logic             isLastSec;
    logic             fwdDay;
    logic             backDay;

    logic [7:0]       rdVal;
    logic [7:0]       timeBytes [3];

    // Bank bit gates the extended registers
    assign bank1   = rate_r[RATE_BANK];
    assign wrCtrl  = regWrStb && regAddr == ADDR_CTRL;
    assign rdFlags = regRdStb && regAddr == ADDR_FLAGS;

    // Divider chain clocked by the sampled oscillator level
    // A rate change may fake one tap edge
    assign oscRise = oscLevel && !oscPrev_r;
    assign running = !rate_r[RATE_RST] && rate_r[RATE_OSC];
    assign secTick = running && oscRise && div_r == DIV_LAST;
    assign tap     = div_r[TAP_OF_RS[rate_r[3:0]]];
    assign periodicEvt = running && rate_r[3:0] != RS_NONE && tap && !tapPrev_r;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_r     <= '0;
            oscPrev_r <= 1'b0;
            tapPrev_r <= 1'b0;
        end else begin
            oscPrev_r <= oscLevel;
            tapPrev_r <= tap;
            if (rate_r[RATE_RST] || !rate_r[RATE_OSC]) begin
                div_r <= '0;
            end else if (oscRise) begin
                div_r <= div_r + 1'b1;
            end
        end
    end

    // Summer-time checks at 1:59:59 AM
    // Fall-back guard rearms at 2 AM
    assign isLastSec = ctrl_r[CB_DM]
        ? (timeNow.sec == LAST_SEC_BIN && timeNow.min == LAST_SEC_BIN)
        : (timeNow.sec == LAST_SEC_BCD && timeNow.min == LAST_SEC_BCD);
    assign fwdDay = timeNow.month == MON_APRIL && timeNow.dow == DOW_SUNDAY
        && timeNow.date <= DATE_WEEK1_END;
    assign backDay = timeNow.dow == DOW_SUNDAY && (ctrl_r[CB_DM]
        ? (timeNow.month == MON_OCT_BIN && timeNow.date >= DATE_LAST_BIN)
        : (timeNow.month == MON_OCT_BCD && timeNow.date >= DATE_LAST_BCD));

    // One-second update: advance, or a summer-time load instead of the advance
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            advance_r    <= 1'b0;
            summerFwd_r  <= 1'b0;
            summerBack_r <= 1'b0;
            checkPend_r  <= 1'b0;
            checkDly_r   <= 1'b0;
            backDone_r   <= 1'b0;
        end else begin
            advance_r    <= 1'b0;
            summerFwd_r  <= 1'b0;
            summerBack_r <= 1'b0;
            // Second stage: counter has the new second
            checkDly_r   <= secTick;
            checkPend_r  <= checkDly_r;
            if (timeNow.hour == HOUR_TWO_AM) begin
                backDone_r <= 1'b0;
            end
            if (secTick && !ctrl_r[CB_SET]) begin
                if (ctrl_r[CB_DSE] && isLastSec && timeNow.hour == HOUR_ONE_AM
                        && fwdDay) begin
                    summerFwd_r <= 1'b1;
                end else if (ctrl_r[CB_DSE] && isLastSec
                        && timeNow.hour == HOUR_ONE_AM && backDay && !backDone_r) begin
                    summerBack_r <= 1'b1;
                    backDone_r   <= 1'b1;
                end else begin
                    advance_r <= 1'b1;
                end
            end
        end
    end

    // Alarm compare one cycle after the update, on the fresh time
    assign timeBytes[0] = timeNow.sec;
    assign timeBytes[1] = timeNow.min;
    assign timeBytes[2] = timeNow.hour;
    for (genvar i = 0; i < 3; i++) begin : gAlm
        assign almHit[i] = alarm_r[i][7:6] == ALM_DONT_CARE
            || alarm_r[i] == timeBytes[i];
    end
    assign alarmEvt = checkPend_r && &almHit;

    // Flag register: read clears, but a new event in the same cycle wins
    always_comb begin
        flagsNxt = flags_r;
        if (rdFlags) begin
            flagsNxt = '0;
        end
        if (periodicEvt) begin
            flagsNxt[FL_PF-FL_UF] = 1'b1;
        end
        if (alarmEvt) begin
            flagsNxt[FL_AF-FL_UF] = 1'b1;
        end
        if (checkPend_r) begin
            flagsNxt[0] = 1'b1;
        end
    end

    // Extended flags clear only by a written 0
    always_comb begin
        xflagsNxt = xflags_r;
        if (regWrStb && bank1 && regAddr == ADDR_XFLAGS) begin
            xflagsNxt = xflags_r & regWrData[2:0];
        end
        xflagsNxt[XF_WAKE] = xflagsNxt[XF_WAKE] | wakeEvent;
        xflagsNxt[XF_KICK] = xflagsNxt[XF_KICK] | kickEvent;
        xflagsNxt[XF_RCLR] = xflagsNxt[XF_RCLR] | ramClrEvent;
    end

    always_comb begin
        ctrlNxt = ctrl_r;
        if (wrCtrl) begin
            ctrlNxt = regWrData;
            if (regWrData[CB_SET] && !ctrl_r[CB_SET]) begin
                ctrlNxt[CB_UIE] = 1'b0;
            end
        end
        xctrlNxt = xctrl_r;
        if (regWrStb && bank1 && regAddr == ADDR_XCTRL) begin
            xctrlNxt = regWrData;
        end
    end

    // Summary from next-state values so enable writes take effect at once
    assign anyNxt = (flagsNxt[FL_PF-FL_UF] && ctrlNxt[CB_PIE])
        || (flagsNxt[FL_AF-FL_UF] && ctrlNxt[CB_AIE])
        || (flagsNxt[0] && ctrlNxt[CB_UIE])
        || |(xflagsNxt & xctrlNxt[2:0]);
    assign anyNow = (flags_r[FL_PF-FL_UF] && ctrl_r[CB_PIE])
        || (flags_r[FL_AF-FL_UF] && ctrl_r[CB_AIE])
        || (flags_r[0] && ctrl_r[CB_UIE])
        || |(xflags_r & xctrl_r[2:0]);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flags_r  <= '0;
            xflags_r <= '0;
            ctrl_r   <= CTRL_RST_VAL;
            xctrl_r  <= XCTRL_RST_VAL;
        end else begin
            flags_r  <= flagsNxt;
            xflags_r <= xflagsNxt;
            ctrl_r   <= ctrlNxt;
            xctrl_r  <= xctrlNxt;
        end
    end

    // Open-drain interrupt line: driven low while any pair is active
    // Data stays low; the enable moves the pin
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irqOe_r  <= 1'b0;
            irqOut_r <= 1'b0;
        end else begin
            irqOe_r  <= anyNxt;
            irqOut_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sqwOut_r <= 1'b0;
        // Fixed 32k output: oscillator, two cycles late
        end else if (xctrl_r[XC_FIXED_32K_ENABLE]) begin
            sqwOut_r <= oscPrev_r;
        end else begin
            sqwOut_r <= ctrl_r[CB_SQUARE_WAVE_ENABLE] && rate_r[3:0] != RS_NONE && tap;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fmt_r <= '0;
        end else begin
            // Copies lag the control bits by a cycle
            fmt_r.binary <= ctrl_r[CB_DM];
            fmt_r.hour24 <= ctrl_r[CB_24H];
            fmt_r.hold   <= ctrl_r[CB_SET];
        end
    end

    // Plain registers written by software
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rate_r     <= RATE_RST_VAL;
            xramAddr_r <= '0;
            alarm_r    <= '{default: '0};
            timeWr_r   <= '0;
        end else begin
            timeWr_r.en <= 1'b0;
            if (regWrStb) begin
                if (regAddr == ADDR_RATE) begin
                    rate_r <= {1'b0, regWrData[6:0]};
                end
                if (bank1 && regAddr == ADDR_XRAM_A) begin
                    xramAddr_r <= {1'b0, regWrData[6:0]};
                end
                if (regAddr == ADDR_SEC_ALM) begin
                    alarm_r[0] <= regWrData;
                end
                if (regAddr == ADDR_MIN_ALM) begin
                    alarm_r[1] <= regWrData;
                end
                if (regAddr == ADDR_HOUR_ALM) begin
                    alarm_r[2] <= regWrData;
                end
                if (regAddr <= ADDR_YEAR && regAddr != ADDR_SEC_ALM
                        && regAddr != ADDR_MIN_ALM && regAddr != ADDR_HOUR_ALM) begin
                    timeWr_r <= '{en: 1'b1, addr: regAddr, data: regWrData};
                end
            end
        end
    end

    // User RAM, never blocked by the update cycle
    // No reset: contents undefined until written
    always_ff @(posedge clk_sys) begin
        if (regWrStb && regAddr >= ADDR_RAM_LO
                && (regAddr < ADDR_EXT_LO || (!bank1 && regAddr <= ADDR_TOP))) begin
            ram0[7'(regAddr - ADDR_RAM_LO)] <= regWrData;
        end
        if (regWrStb && bank1 && regAddr == ADDR_XRAM_D) begin
            ram1[xramAddr_r[6:0]] <= regWrData;
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        rdVal = '0;
        case (regAddr)
            ADDR_SEC:      rdVal = timeNow.sec;
            ADDR_SEC_ALM:  rdVal = alarm_r[0];
            ADDR_MIN:      rdVal = timeNow.min;
            ADDR_MIN_ALM:  rdVal = alarm_r[1];
            ADDR_HOUR:     rdVal = timeNow.hour;
            ADDR_HOUR_ALM: rdVal = alarm_r[2];
            ADDR_DOW:      rdVal = timeNow.dow;
            ADDR_DATE:     rdVal = timeNow.date;
            ADDR_MONTH:    rdVal = timeNow.month;
            ADDR_YEAR:     rdVal = timeNow.year;
            ADDR_RATE:     rdVal = rate_r;
            ADDR_CTRL:     rdVal = ctrl_r;
            ADDR_FLAGS:    rdVal = {anyNow, flags_r, 4'h0};
            ADDR_BATT:     rdVal = {mainBatteryOk || auxBatteryOk, 7'h00};
            default: begin
                if (bank1 && regAddr == ADDR_XFLAGS) begin
                    rdVal = {5'h00, xflags_r};
                end else if (bank1 && regAddr == ADDR_XCTRL) begin
                    rdVal = xctrl_r;
                end else if (bank1 && regAddr == ADDR_XRAM_A) begin
                    rdVal = xramAddr_r;
                end else if (bank1 && regAddr == ADDR_XRAM_D) begin
                    rdVal = ram1[xramAddr_r[6:0]];
                end else if (regAddr >= ADDR_RAM_LO && (regAddr < ADDR_EXT_LO
                        || (!bank1 && regAddr <= ADDR_TOP))) begin
                    rdVal = ram0[7'(regAddr - ADDR_RAM_LO)];
                end
            end
        endcase
    end

    // Data stand in the cycle after the read strobe only
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            regRdData_r <= '0;
        end else begin
            regRdData_r <= regRdStb ? rdVal : 8'h00;
        end
    end
endmodule

/* test/rcs_ctrl_monitor.sv */
// Assertion checker for the clock control, status and interrupt block
`timescale 1ns/10ps
module rcs_ctrl_monitor
    import rcs_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       rst_n,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWrStb,
    input wire logic       regRdStb,
    input wire logic [7:0] regRdData_r,
    input wire logic       mainBatteryOk,
    input wire logic       auxBatteryOk,
    input wire logic       advance_r,
    input wire rcs_fmt_t   fmt_r,
    input wire rcs_twr_t   timeWr_r,
    input wire logic       irqOut_r,
    input wire logic       irqOe_r
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_rd(logic [7:0] a);
        regRdStb && regAddr == a;
    endsequence
    sequence s_wr(logic [7:0] a);
        regWrStb && regAddr == a;
    endsequence

    a_flag_low_zero: assert property (s_rd(ADDR_FLAGS) |=> regRdData_r[3:0] == 4'h0)
        else $error("flag register low bits not zero");
    a_batt_read: assert property (s_rd(ADDR_BATT) |=>
        regRdData_r == {$past(mainBatteryOk | auxBatteryOk), 7'h00})
        else $error("battery status read wrong");
    a_summary_irq: assert property (s_rd(ADDR_FLAGS) |=> regRdData_r[FL_ANY] == $past(irqOe_r))
        else $error("summary flag disagrees with interrupt line");
    a_dm_follow: assert property (s_wr(ADDR_CTRL) |=> ##1
        fmt_r.binary == $past(regWrData[CB_DM], 2))
        else $error("data format output wrong");
    a_hour_follow: assert property (s_wr(ADDR_CTRL) |=> ##1
        fmt_r.hour24 == $past(regWrData[CB_24H], 2))
        else $error("hour format output wrong");
    a_hold_follow: assert property (s_wr(ADDR_CTRL) |=> ##1
        fmt_r.hold == $past(regWrData[CB_SET], 2))
        else $error("update inhibit output wrong");
    a_hold_blocks: assert property (fmt_r.hold |-> !advance_r)
        else $error("time advanced while inhibited");
    a_time_load: assert property (s_wr(ADDR_SEC) |=>
        timeWr_r.en && timeWr_r.data == $past(regWrData))
        else $error("seconds load not passed on");
    a_irq_data_low: assert property (irqOut_r == 1'b0)
        else $error("interrupt data not low");
    a_rd_idle: assert property (!$past(regRdStb) |-> regRdData_r == 8'h00)
        else $error("read data outside read cycle");
endmodule

bind rcs_ctrl rcs_ctrl_monitor i_mon (.clk_sys, .rst_n, .regAddr, .regWrData, .regWrStb,
    .regRdStb, .regRdData_r, .mainBatteryOk, .auxBatteryOk, .advance_r, .fmt_r, .timeWr_r,
    .irqOut_r, .irqOe_r);

/* test/rcs_time_model.sv */
// Time counter and oscillator standing beside the control block
`timescale 1ns/10ps
module rcs_time_model
    import rcs_pkg::*;
(
    input wire logic      clk_sys,
    input wire logic      rst_n,
    input wire logic      advance,
    input wire logic      summerFwd,
    input wire logic      summerBack,
    input wire rcs_twr_t  timeWr,
    output logic          oscLevel,
    output rcs_time_t     timeNow
);
    // Oscillator scaled to the clock so that one second fits the run
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) oscLevel <= 1'b0;
        else oscLevel <= ~oscLevel;
    end

    // Binary seconds only; carries are not needed by the scenarios
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            timeNow <= '0;
        end else if (timeWr.en) begin
            case (timeWr.addr)
                ADDR_SEC:  timeNow.sec <= timeWr.data;
                ADDR_MIN:  timeNow.min <= timeWr.data;
                ADDR_HOUR: timeNow.hour <= timeWr.data;
                default:   timeNow.year <= timeNow.year;
            endcase
        end else if (summerFwd || summerBack) begin
            timeNow.hour <= summerFwd ? 8'h03 : 8'h01;
            timeNow.min <= 8'h00;
            timeNow.sec <= 8'h00;
        end else if (advance) begin
            timeNow.sec <= timeNow.sec + 8'h01;
        end
    end
endmodule

/* test/test_rtc_control_status_interrupts.sv */
// Self-checking testbench for the clock control, status and interrupt block
`timescale 1ns/10ps
module test_rtc_control_status_interrupts
    import rcs_pkg::*;
;
    logic       clk_sys = 1'b0;
    logic       rst_n = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic       regWrStb = 1'b0;
    logic       regRdStb = 1'b0;
    logic [2:0] extEvt = 3'h0;
    logic       mainBatteryOk = 1'b1;
    logic       auxBatteryOk = 1'b1;
    logic [7:0] regRdData_r;
    logic       oscLevel, advance_r, summerFwd_r, summerBack_r, sqwOut_r, irqOut_r, irqOe_r;
    rcs_time_t  timeNow;
    rcs_fmt_t   fmt_r;
    rcs_twr_t   timeWr_r;
    int         mismatches = 0;
    int         num_checks = 0;
    int         p;

    always #4 clk_sys = ~clk_sys;

    rcs_ctrl i_dut (.clk_sys, .rst_n, .regAddr, .regWrData, .regWrStb, .regRdStb,
        .regRdData_r, .oscLevel, .timeNow, .wakeEvent(extEvt[0]), .kickEvent(extEvt[1]),
        .ramClrEvent(extEvt[2]), .mainBatteryOk, .auxBatteryOk, .advance_r, .summerFwd_r,
        .summerBack_r, .fmt_r, .timeWr_r, .sqwOut_r, .irqOut_r, .irqOe_r);

    rcs_time_model i_time (.clk_sys, .rst_n, .advance(advance_r), .summerFwd(summerFwd_r),
        .summerBack(summerBack_r), .timeWr(timeWr_r), .oscLevel, .timeNow);

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        regWrStb <= 1'b1;
        regAddr <= a;
        regWrData <= v;
        @(posedge clk_sys);
        regWrStb <= 1'b0;
        #1;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        regRdStb <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRdStb <= 1'b0;
        #1;
        chk8(regRdData_r, exp);
    endtask

    task automatic irqchk(input logic exp);
        chk8({7'h00, irqOe_r}, {7'h00, exp});
    endtask

    // Edge to edge time of the square-wave pin, in clock cycles
    task automatic period(output int n);
        longint t0;
        @(posedge sqwOut_r);
        t0 = $time;
        @(posedge sqwOut_r);
        n = int'(($time - t0) / 8);
    endtask

    task automatic t_reset_bus;
        rdchk(ADDR_CTRL, CTRL_RST_VAL);
        rdchk(ADDR_RATE, RATE_RST_VAL);
        rdchk(ADDR_FLAGS, 8'h00);
        rdchk(8'h80, 8'h00);
        $display("reset and bus test done");
    endtask

    task automatic t_battery;
        rdchk(ADDR_BATT, 8'h80);
        @(posedge clk_sys) mainBatteryOk <= 1'b0;
        rdchk(ADDR_BATT, 8'h80);
        @(posedge clk_sys) auxBatteryOk <= 1'b0;
        rdchk(ADDR_BATT, 8'h00);
        @(posedge clk_sys) mainBatteryOk <= 1'b1;
        wr(ADDR_BATT, 8'hFF);
        rdchk(ADDR_BATT, 8'h80);
        @(posedge clk_sys) auxBatteryOk <= 1'b1;
        $display("battery test done");
    endtask

    task automatic t_control;
        wr(ADDR_CTRL, 8'h2F);
        rdchk(ADDR_CTRL, 8'h2F);
        chk8({5'h00, fmt_r}, 8'h06);
        wr(ADDR_CTRL, 8'h90);
        rdchk(ADDR_CTRL, 8'h80);
        chk8({5'h00, fmt_r}, 8'h01);
        wr(ADDR_SEC, 8'h00);
        wr(ADDR_CTRL, 8'h10);
        rdchk(ADDR_CTRL, 8'h10);
        wr(ADDR_CTRL, 8'h00);
        $display("control test done");
    endtask

    task automatic t_ram;
        wr(ADDR_RAM_LO, 8'h5A);
        wr(ADDR_TOP, 8'h3C);
        rdchk(ADDR_RAM_LO, 8'h5A);
        rdchk(ADDR_TOP, 8'h3C);
        wr(ADDR_RATE, 8'h30);
        wr(ADDR_XRAM_A, 8'h7F);
        wr(ADDR_XRAM_D, 8'hA5);
        rdchk(ADDR_XRAM_D, 8'hA5);
        rdchk(ADDR_RAM_LO, 8'h5A);
        wr(ADDR_RATE, 8'h20);
        rdchk(ADDR_TOP, 8'h3C);
        $display("user RAM test done");
    endtask

    task automatic t_periodic;
        wr(ADDR_FLAGS, 8'hFF);
        rdchk(ADDR_FLAGS, 8'h00);
        wr(ADDR_RATE, 8'h26);
        repeat (80) @(posedge clk_sys);
        wr(ADDR_RATE, 8'h20);
        irqchk(1'b0);
        wr(ADDR_CTRL, 8'h40);
        irqchk(1'b1);
        rdchk(ADDR_FLAGS, 8'hC0);
        irqchk(1'b0);
        rdchk(ADDR_FLAGS, 8'h00);
        wr(ADDR_CTRL, 8'h00);
        $display("periodic test done");
    endtask

    task automatic t_ext_flags;
        wr(ADDR_RATE, 8'h30);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_sys);
            extEvt[i] <= 1'b1;
            @(posedge clk_sys);
            extEvt[i] <= 1'b0;
            rdchk(ADDR_XFLAGS, 8'h01 << i);
            rdchk(ADDR_XFLAGS, 8'h01 << i);
            irqchk(1'b0);
            wr(ADDR_XCTRL, 8'h01 << i);
            irqchk(1'b1);
            rdchk(ADDR_FLAGS, 8'h80);
            irqchk(1'b1);
            wr(ADDR_XFLAGS, 8'h00);
            irqchk(1'b0);
            wr(ADDR_XCTRL, 8'h00);
        end
        wr(ADDR_RATE, 8'h20);
        $display("extended flag test done");
    endtask

    task automatic t_square_wave;
        logic lo;
        wr(ADDR_RATE, 8'h26);
        wr(ADDR_CTRL, 8'h08);
        period(p);
        chk8(p[7:0], 8'h40);
        wr(ADDR_CTRL, 8'h00);
        repeat (2) @(posedge clk_sys);
        lo = 1'b0;
        repeat (100) @(posedge clk_sys) lo = lo | sqwOut_r;
        chk8({7'h00, lo}, 8'h00);
        wr(ADDR_RATE, 8'h30);
        wr(ADDR_XCTRL, 8'h20);
        period(p);
        chk8(p[7:0], 8'h02);
        wr(ADDR_XCTRL, 8'h00);
        wr(ADDR_RATE, 8'h20);
        $display("square wave test done");
    endtask

    task automatic t_update;
        int n;
        wr(ADDR_SEC_ALM, 8'hC0);
        wr(ADDR_MIN_ALM, 8'hC0);
        wr(ADDR_HOUR_ALM, 8'hC0);
        rdchk(ADDR_FLAGS, 8'h40);
        wr(ADDR_CTRL, 8'h20);
        n = 0;
        while (advance_r !== 1'b1 && n < 70000) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk8({7'h00, advance_r}, 8'h01);
        repeat (4) @(posedge clk_sys);
        #1;
        irqchk(1'b1);
        rdchk(ADDR_FLAGS, 8'hB0);
        irqchk(1'b0);
        wr(ADDR_CTRL, 8'h00);
        $display("update test done");
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        repeat (90000) @(posedge clk_sys);
        mismatches++;
        $display("watchdog expired");
        results();
    end

    initial begin
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset_bus();
        t_battery();
        t_control();
        t_ram();
        t_periodic();
        t_ext_flags();
        t_square_wave();
        t_update();
        results();
    end
endmodule
